// >>> logic/sebw_pkg.sv
// Constants, types and carriers shared by the serial memory byte write port
// ==========================================================================
package sebw_pkg;

    // ==========================================================================
    // Array geometry
    localparam int unsigned SEBW_PAGE_COUNT = 16;
    localparam int unsigned SEBW_PAGE_BYTES = 16;
    localparam int unsigned SEBW_MEM_DEPTH = SEBW_PAGE_COUNT * SEBW_PAGE_BYTES;
    localparam int unsigned SEBW_ADDR_W = 8;
    localparam int unsigned SEBW_DATA_W = 8;
    localparam logic [7:0] SEBW_ERASED_BYTE = 8'hff;

    // ==========================================================================
    // Serial word framing: bit counter values
    localparam logic [3:0] SEBW_BIT_FIRST_DONE = 4'h1;
    localparam logic [3:0] SEBW_BIT_LAST = 4'h7;
    localparam logic [3:0] SEBW_BIT_ACK = 4'h8;
    localparam logic [3:0] SEBW_BIT_RESET = 4'h0;

    // Device address word fields
    localparam int unsigned SEBW_TYPE_MSB = 7;
    localparam int unsigned SEBW_TYPE_LSB = 4;
    localparam int unsigned SEBW_CS_MSB = 3;
    localparam int unsigned SEBW_CS_LSB = 1;
    localparam int unsigned SEBW_RW_BIT = 0;
    // Arbitrary neutral value; override at the top level
    localparam logic [3:0] SEBW_TYPE_CODE_DEFAULT = 4'h5;

    // ==========================================================================
    // Timing
    localparam int unsigned SEBW_CLK_PERIOD_NS = 20;
    localparam int unsigned SEBW_WRITE_CYCLE_TIME_NS = 5000000;
    // Longest time, so the division rounds down
    localparam int unsigned SEBW_WRITE_CYCLE_CYCLES = SEBW_WRITE_CYCLE_TIME_NS / SEBW_CLK_PERIOD_NS;
    localparam int unsigned SEBW_PROG_CNT_W = 18;
    localparam logic [17:0] SEBW_PROG_CNT_RESET = 18'h0;

    // ==========================================================================
    // States
    typedef enum logic [2:0] {
        SEBW_LS_IDLE,
        SEBW_LS_DEV,
        SEBW_LS_WADDR,
        SEBW_LS_WDATA,
        SEBW_LS_RACK,
        SEBW_LS_READ
    } sebw_link_state_t;

    typedef enum logic [1:0] {
        SEBW_PS_IDLE,
        SEBW_PS_ERASE,
        SEBW_PS_PROG
    } sebw_prog_state_t;

    // Write request handed from link to programming logic
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } sebw_wr_req_t;

    localparam sebw_wr_req_t SEBW_WR_REQ_RESET = '{addr: 8'h00, data: 8'h00};

endpackage : sebw_pkg

// >>> logic/sebw_eeprom_port.sv
// Two-wire serial memory slave: link on the serial clock, programming on clk
`timescale 1ns/1ps

module sebw_eeprom_port #(
    parameter int unsigned WRITE_CYCLES = sebw_pkg::SEBW_WRITE_CYCLE_CYCLES,
    parameter logic [3:0] TYPE_CODE = sebw_pkg::SEBW_TYPE_CODE_DEFAULT // Arbitrary value
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // Straps
    input wire logic chip_select_bit2,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit0,
    input wire logic write_protect,
    // Status
    output logic standby,
    output logic busy
);

    // ==========================================================================
    // Declarations
    // Array content is not reset; unwritten bytes read unknown
    logic [7:0] mem_q [sebw_pkg::SEBW_MEM_DEPTH];

    // Link domain
    logic start_q;
    logic stop_q;
    logic start_seen_q;
    logic start_clr_n;
    logic stop_clr_n;
    sebw_pkg::sebw_link_state_t state_q;
    sebw_pkg::sebw_link_state_t state_d;
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic [7:0] rx_q;
    logic [7:0] rx_d;
    logic [7:0] rd_shift_q;
    logic [7:0] rd_shift_d;
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic ack_q;
    logic ack_d;
    logic wr_valid_q;
    logic wr_valid_d;
    sebw_pkg::sebw_wr_req_t wr_req_q;
    sebw_pkg::sebw_wr_req_t wr_req_d;
    logic sda_drive_q;
    logic [2:0] cs_meta_q;
    logic [2:0] cs_sync_q;
    logic busy_meta_q;
    logic busy_sync_q;
    // Registered idle decode, so the crossing never sees a decode glitch
    logic link_idle_q;

    // System domain
    logic stop_meta_q;
    logic stop_sync_q;
    logic stop_prev_q;
    logic wrv_meta_q;
    logic wrv_sync_q;
    logic idle_meta_q;
    logic idle_sync_q;
    logic wp_meta_q;
    logic wp_sync_q;
    sebw_pkg::sebw_prog_state_t pstate_q;
    sebw_pkg::sebw_prog_state_t pstate_d;
    // Programming counter wide enough for the full write cycle time
    logic [17:0] pcnt_q;
    logic [17:0] pcnt_d;
    sebw_pkg::sebw_wr_req_t prog_req_q;
    sebw_pkg::sebw_wr_req_t prog_req_d;

    // ==========================================================================
    // Link decode
    // Word includes the bit sampled now, so decisions land on the eighth rise
    wire logic [7:0] word = {rx_q[6:0], sda_i};
    wire logic word_done = (cnt_q == sebw_pkg::SEBW_BIT_LAST);
    wire logic ack_slot = (cnt_q == sebw_pkg::SEBW_BIT_ACK);
    wire logic type_ok = (word[sebw_pkg::SEBW_TYPE_MSB:sebw_pkg::SEBW_TYPE_LSB] == TYPE_CODE);
    wire logic cs_ok = (word[sebw_pkg::SEBW_CS_MSB:sebw_pkg::SEBW_CS_LSB] == cs_sync_q);
    // A busy device refuses its address, which lets the master poll
    wire logic dev_match = type_ok && cs_ok && !busy_sync_q;
    wire logic rd_dir = word[sebw_pkg::SEBW_RW_BIT];
    wire logic [7:0] rd_byte = mem_q[addr_q];
    // Read bits are driven everywhere but the master's acknowledge slot
    wire logic tx_phase = (state_q == sebw_pkg::SEBW_LS_READ) && !ack_slot;
    wire logic drive_next = !start_q && (ack_q || (tx_phase && !rd_shift_q[7]));

    // Open-drain pin: only ever low or released
    assign sda_o = 1'b0;
    assign sda_oe_n = !sda_drive_q;

    // Frame markers clear themselves from the link side
    // START clears one clock fall later; STOP stands until the next START
    assign start_clr_n = reset_n && !start_seen_q;
    assign stop_clr_n = reset_n && !start_q;

    // ==========================================================================
    // START and STOP capture; relies on data being stable while the clock is high
    // START: data falls with clock high
    always_ff @(negedge sda_i or negedge start_clr_n) begin
        if (!start_clr_n) begin
            start_q <= 1'b0;
        end else begin
            start_q <= scl_in;
        end
    end

    // STOP: data rises with clock high, held until the next START
    always_ff @(posedge sda_i or negedge stop_clr_n) begin
        if (!stop_clr_n) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= scl_in;
        end
    end

    // ==========================================================================
    // Link next state
    always_comb begin
        state_d = state_q;
        cnt_d = ack_slot ? sebw_pkg::SEBW_BIT_RESET : cnt_q + 4'h1;
        rx_d = word;
        rd_shift_d = rd_shift_q;
        addr_d = addr_q;
        ack_d = 1'b0;
        wr_valid_d = wr_valid_q;
        wr_req_d = wr_req_q;
        if (start_seen_q) begin
            // New command; any half-received write is dropped
            state_d = sebw_pkg::SEBW_LS_DEV;
            cnt_d = sebw_pkg::SEBW_BIT_FIRST_DONE;
            wr_valid_d = 1'b0;
        end else begin
            case (state_q)
                sebw_pkg::SEBW_LS_DEV: begin
                    if (word_done) begin
                        if (dev_match) begin
                            ack_d = 1'b1;
                            state_d = rd_dir ? sebw_pkg::SEBW_LS_RACK : sebw_pkg::SEBW_LS_WADDR;
                        end else begin
                            // Wrong type code or straps, or busy: silent until the next START
                            state_d = sebw_pkg::SEBW_LS_IDLE;
                        end
                    end
                end
                // Word address loads the counter for reads and writes alike
                sebw_pkg::SEBW_LS_WADDR: begin
                    if (word_done) begin
                        addr_d = word;
                        ack_d = 1'b1;
                        state_d = sebw_pkg::SEBW_LS_WDATA;
                    end
                end
                // One data byte per write; later bytes land in idle unacknowledged
                sebw_pkg::SEBW_LS_WDATA: begin
                    if (word_done) begin
                        ack_d = 1'b1;
                        wr_req_d = '{addr: addr_q, data: word};
                        wr_valid_d = 1'b1;
                        addr_d = addr_q + 8'h01;
                        state_d = sebw_pkg::SEBW_LS_IDLE;
                    end
                end
                // First byte loaded for the clock fall after the acknowledge
                sebw_pkg::SEBW_LS_RACK: begin
                    if (ack_slot) begin
                        rd_shift_d = rd_byte;
                        addr_d = addr_q + 8'h01;
                        state_d = sebw_pkg::SEBW_LS_READ;
                    end
                end
                // Master acknowledge fetches the next byte, a nack ends the read
                sebw_pkg::SEBW_LS_READ: begin
                    if (ack_slot) begin
                        if (!sda_i) begin
                            rd_shift_d = rd_byte;
                            addr_d = addr_q + 8'h01;
                        end else begin
                            state_d = sebw_pkg::SEBW_LS_IDLE;
                        end
                    end else begin
                        rd_shift_d = {rd_shift_q[6:0], 1'b1};
                    end
                end
                sebw_pkg::SEBW_LS_IDLE: begin
                    state_d = sebw_pkg::SEBW_LS_IDLE;
                end
                default: begin
                    state_d = sebw_pkg::SEBW_LS_IDLE;
                end
            endcase
        end
    end

    // ==========================================================================
    // Link registers, sampled on clock rise
    // Framing: state, bit counter and shift registers
    always_ff @(posedge scl_in or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= sebw_pkg::SEBW_LS_IDLE;
            cnt_q <= sebw_pkg::SEBW_BIT_RESET;
            rx_q <= 8'h00;
            rd_shift_q <= 8'hff;
            ack_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            rx_q <= rx_d;
            rd_shift_q <= rd_shift_d;
            ack_q <= ack_d;
        end
    end

    // Word address counter and the write request handed to programming
    always_ff @(posedge scl_in or negedge reset_n) begin
        if (!reset_n) begin
            addr_q <= 8'h00;
            wr_valid_q <= 1'b0;
            wr_req_q <= sebw_pkg::SEBW_WR_REQ_RESET;
        end else begin
            addr_q <= addr_d;
            wr_valid_q <= wr_valid_d;
            wr_req_q <= wr_req_d;
        end
    end

    // Idle flag for the status crossing; follows the state register exactly
    always_ff @(posedge scl_in or negedge reset_n) begin
        if (!reset_n) begin
            link_idle_q <= 1'b1;
        end else begin
            link_idle_q <= (state_d == sebw_pkg::SEBW_LS_IDLE);
        end
    end

    // Strap and busy synchronisers on the link clock; straps read low from reset until the second clock rise
    always_ff @(posedge scl_in or negedge reset_n) begin
        if (!reset_n) begin
            cs_meta_q <= 3'h0;
            cs_sync_q <= 3'h0;
            busy_meta_q <= 1'b0;
            busy_sync_q <= 1'b0;
        end else begin
            cs_meta_q <= {chip_select_bit2, chip_select_bit1, chip_select_bit0};
            cs_sync_q <= cs_meta_q;
            busy_meta_q <= busy;
            busy_sync_q <= busy_meta_q;
        end
    end

    // Output side, updated on clock fall
    // Pulling low only after the clock falls keeps data steady while it is high
    always_ff @(negedge scl_in or negedge reset_n) begin
        if (!reset_n) begin
            start_seen_q <= 1'b0;
            sda_drive_q <= 1'b0;
        end else begin
            start_seen_q <= start_q;
            sda_drive_q <= drive_next;
        end
    end

    // ==========================================================================
    // Crossing into the system clock, two flip-flops per signal
    // STOP level, plus one more stage for its rising edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stop_meta_q <= 1'b0;
            stop_sync_q <= 1'b0;
            stop_prev_q <= 1'b0;
        end else begin
            stop_meta_q <= stop_q;
            stop_sync_q <= stop_meta_q;
            stop_prev_q <= stop_sync_q;
        end
    end

    // Write valid and link idle, both launched from link flip-flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrv_meta_q <= 1'b0;
            wrv_sync_q <= 1'b0;
            idle_meta_q <= 1'b1;
            idle_sync_q <= 1'b1;
        end else begin
            wrv_meta_q <= wr_valid_q;
            wrv_sync_q <= wrv_meta_q;
            idle_meta_q <= link_idle_q;
            idle_sync_q <= idle_meta_q;
        end
    end

    // Write-protect pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_meta_q <= 1'b0;
            wp_sync_q <= 1'b0;
        end else begin
            wp_meta_q <= write_protect;
            wp_sync_q <= wp_meta_q;
        end
    end

    // ==========================================================================
    // Programming control
    wire logic stop_rise = stop_sync_q && !stop_prev_q;
    wire logic prog_go = stop_rise && wrv_sync_q && !wp_sync_q;
    // Erase takes one cycle, so the programming phase counts one fewer, starting from zero
    wire logic prog_done = (pcnt_q == WRITE_CYCLES[17:0] - 18'h2);
    wire logic mem_we = (pstate_q == sebw_pkg::SEBW_PS_ERASE) || ((pstate_q == sebw_pkg::SEBW_PS_PROG) && prog_done);
    wire logic [7:0] mem_wdata = (pstate_q == sebw_pkg::SEBW_PS_ERASE) ? sebw_pkg::SEBW_ERASED_BYTE : prog_req_q.data;

    // Programming sequencer: erase, then count out the write cycle time
    always_comb begin
        pstate_d = pstate_q;
        pcnt_d = pcnt_q;
        prog_req_d = prog_req_q;
        case (pstate_q)
            sebw_pkg::SEBW_PS_IDLE: begin
                if (prog_go) begin
                    prog_req_d = wr_req_q; // Stable while the valid level stands
                    pstate_d = sebw_pkg::SEBW_PS_ERASE;
                end
            end
            // One cycle writes the erased value before the new byte
            sebw_pkg::SEBW_PS_ERASE: begin
                pcnt_d = sebw_pkg::SEBW_PROG_CNT_RESET;
                pstate_d = sebw_pkg::SEBW_PS_PROG;
            end
            sebw_pkg::SEBW_PS_PROG: begin
                pcnt_d = pcnt_q + 18'h1;
                if (prog_done) begin
                    pstate_d = sebw_pkg::SEBW_PS_IDLE;
                end
            end
            default: begin
                pstate_d = sebw_pkg::SEBW_PS_IDLE;
            end
        endcase
    end

    // Programming registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pstate_q <= sebw_pkg::SEBW_PS_IDLE;
            pcnt_q <= sebw_pkg::SEBW_PROG_CNT_RESET;
            prog_req_q <= sebw_pkg::SEBW_WR_REQ_RESET;
        end else begin
            pstate_q <= pstate_d;
            pcnt_q <= pcnt_d;
            prog_req_q <= prog_req_d;
        end
    end

    // Array write port: erase first, then the new value
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_q[prog_req_q.addr] <= mem_wdata;
        end
    end

    // ==========================================================================
    // Status
    assign busy = (pstate_q != sebw_pkg::SEBW_PS_IDLE);
    // The cycle between a write STOP and the start of programming is not standby
    assign standby = !busy && !prog_go && (stop_sync_q || (idle_sync_q && !wrv_sync_q));

endmodule : sebw_eeprom_port

// >>> tb/sebw_eeprom_port_checker.sv
// Concurrent checks on the serial memory port pins and status
`timescale 1ns/1ps

module sebw_eeprom_port_checker #(
    parameter int unsigned WRITE_CYCLES = 2
) (
    // System clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Two-wire link
    input wire logic scl_in,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_n,
    // Straps
    input wire logic chip_select_bit2,
    input wire logic chip_select_bit1,
    input wire logic chip_select_bit0,
    input wire logic write_protect,
    // Status
    input wire logic standby,
    input wire logic busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // ==========
    // Length of the current busy stretch
    logic [31:0] busy_cnt_q;
    logic [31:0] busy_cnt_d;
    assign busy_cnt_d = busy ? busy_cnt_q + 32'h1 : 32'h0;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_cnt_q <= 32'h0;
        end else begin
            busy_cnt_q <= busy_cnt_d;
        end
    end
    // ==========
    // Pin and status relations
    AST_OD_LOW: assert property (sda_o == 1'b0)
        else $error("data pin value not low");
    AST_OE_SCL_HIGH: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
        else $error("data enable moved while clock high");
    AST_WP_BLOCK: assert property ($rose(busy) |-> !write_protect)
        else $error("programming while protected");
    AST_PROG_LEN: assert property ($fell(busy) |-> busy_cnt_q == WRITE_CYCLES)
        else $error("programming length wrong");
    AST_BUSY_NOT_STBY: assert property (busy |-> !standby)
        else $error("standby while programming");
    AST_STBY_AFTER: assert property ($fell(busy) |-> ##[0:3] standby)
        else $error("no standby after programming");
    AST_NO_ACK_BUSY: assert property (busy |-> sda_oe_n)
        else $error("data pulled while programming");
    AST_PROG_AFTER_STOP: assert property ($rose(busy) |-> scl_in && sda_i)
        else $error("programming began with bus not idle");
    AST_NO_STBY_BEFORE_PROG: assert property ($rose(busy) |-> !$past(standby))
        else $error("standby shown before programming began");
    // Main scenarios reached
    cover property ($rose(busy));
    cover property ($fell(sda_oe_n));
    cover property (write_protect && !sda_oe_n);
endmodule : sebw_eeprom_port_checker

bind sebw_eeprom_port sebw_eeprom_port_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_sebw_eeprom_port_checker (
    .clk(clk), .reset_n(reset_n), .scl_in(scl_in), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .chip_select_bit2(chip_select_bit2), .chip_select_bit1(chip_select_bit1),
    .chip_select_bit0(chip_select_bit0), .write_protect(write_protect), .standby(standby), .busy(busy));

// >>> tb/sebw_master_model.sv
// Two-wire bus master model driving serial clock and data pull-down
`timescale 1ns/1ps

module sebw_master_model (
    // Bus wires
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // ==========
    // Idle bus: clock stands high, data released
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // One bit slot, entered and left with clock low
    task automatic xfer_bit(input logic b, output logic r);
        #8 sda_pull = ~b;
        #24 scl = 1'b1;
        #16 r = sda;
        #16 scl = 1'b0;
    endtask : xfer_bit
    // Data falls with clock high
    task automatic start_c();
        #8 sda_pull = 1'b0;
        #24 scl = 1'b1;
        #16 sda_pull = 1'b1;
        #16 scl = 1'b0;
    endtask : start_c
    // Data rises with clock high, clock then stands
    task automatic stop_c();
        #8 sda_pull = 1'b1;
        #24 scl = 1'b1;
        #16 sda_pull = 1'b0;
        #16;
    endtask : stop_c
    // Byte out MSB first, ack slot read back
    task automatic put_byte(input logic [7:0] v, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(v[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : put_byte
    // Byte in, then own ack or nack
    task automatic get_byte(input logic ack_in, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) xfer_bit(1'b1, v[i]);
        xfer_bit(~ack_in, r);
    endtask : get_byte
    // Bus recovery sequence
    task automatic soft_reset();
        logic r;
        start_c();
        repeat (18) xfer_bit(1'b1, r);
        start_c();
        stop_c();
    endtask : soft_reset
endmodule : sebw_master_model

// >>> tb/sebw_eeprom_port_tb_top.sv
// Self-checking bench for the serial memory byte write port
`timescale 1ns/1ps

module sebw_eeprom_port_tb_top;
    // ==========
    // Constants, wiring and reference memory
    localparam int unsigned W = 100;
    localparam logic [3:0] TC = 4'h5; // Arbitrary type code
    logic clk, reset_n, write_protect, scl, sda_pull, sda_o, sda_oe_n, standby, busy;
    logic [2:0] cs;
    logic [7:0] a, d0, d1;
    int mem [256];
    int n_fail = 0;
    int compares = 0;
    wire sda = ~(sda_pull | ~sda_oe_n);
    sebw_eeprom_port #(.WRITE_CYCLES(W), .TYPE_CODE(TC)) i_sebw_eeprom_port (
        .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .chip_select_bit2(cs[2]), .chip_select_bit1(cs[1]), .chip_select_bit0(cs[0]),
        .write_protect(write_protect), .standby(standby), .busy(busy));
    sebw_master_model i_sebw_master_model (.scl(scl), .sda_pull(sda_pull), .sda(sda));
    // System clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========
    // Compare, close, wait tasks
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim
    task automatic wait_idle(input logic prog);
        logic seen;
        seen = 1'b0;
        for (int i = 0; i < W + 50; i++) begin
            @(posedge clk);
            if (busy === 1'b1) seen = 1'b1;
            if (seen && busy === 1'b0) break;
        end
        if (busy !== 1'b0) begin
            n_fail++;
            end_sim();
        end
        chk({7'h0, seen}, {7'h0, prog});
        #100 chk({7'h0, standby}, 8'h01);
    endtask : wait_idle
    // Device word that must not be acknowledged
    task automatic nak(input logic [7:0] v);
        logic k;
        i_sebw_master_model.start_c();
        i_sebw_master_model.put_byte(v, k);
        chk({7'h0, k}, 8'h00);
        i_sebw_master_model.stop_c();
    endtask : nak
    // Byte write, optionally polled while programming
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt, input logic poll);
        logic k;
        i_sebw_master_model.start_c();
        i_sebw_master_model.put_byte({TC, cs, 1'b0}, k);
        chk({7'h0, k}, 8'h01);
        i_sebw_master_model.put_byte(ad, k);
        chk({7'h0, k}, 8'h01);
        i_sebw_master_model.put_byte(dt, k);
        chk({7'h0, k}, 8'h01);
        i_sebw_master_model.stop_c();
        if (poll) #100 nak({TC, cs, 1'b0});
        if (!write_protect) mem[ad] = dt;
        wait_idle(~write_protect);
    endtask : wr
    // Write cut by repeated start, dummy write, then two-byte read
    task automatic rd2(input logic [7:0] ad);
        logic k;
        logic [7:0] b0, b1;
        i_sebw_master_model.start_c();
        i_sebw_master_model.put_byte({TC, cs, 1'b0}, k);
        i_sebw_master_model.put_byte(ad, k);
        i_sebw_master_model.put_byte(~ad, k); // Data byte that the START must drop
        i_sebw_master_model.start_c();
        i_sebw_master_model.put_byte({TC, cs, 1'b0}, k);
        i_sebw_master_model.put_byte(ad, k);
        i_sebw_master_model.start_c();
        i_sebw_master_model.put_byte({TC, cs, 1'b1}, k);
        chk({7'h0, k}, 8'h01);
        i_sebw_master_model.get_byte(1'b1, b0);
        i_sebw_master_model.get_byte(1'b0, b1);
        i_sebw_master_model.stop_c();
        chk(b0, 8'(mem[ad]));
        chk(b1, 8'(mem[ad + 8'h01]));
        #100 chk({7'h0, busy}, 8'h00);
        chk({7'h0, standby}, 8'h01);
    endtask : rd2
    // ==========
    // Main sequence
    initial begin
        reset_n = 1'b0;
        write_protect = 1'b0;
        void'($urandom(38));
        cs = 3'($urandom);
        repeat (5) @(posedge clk);
        #2 reset_n = 1'b1;
        for (int it = 0; it < 3; it++) begin
            a = (it == 0) ? 8'hff : 8'($urandom);
            d0 = 8'($urandom);
            d1 = 8'($urandom);
            wr(a, d0, it == 1);
            wr(a + 8'h01, d1, 1'b0);
            rd2(a);
            $display("test write_read %0d done", it);
        end
        @(posedge clk);
        #2 write_protect = 1'b1;
        wr(a, ~d0, 1'b0);
        rd2(a);
        $display("test protect done");
        @(posedge clk);
        #2 write_protect = 1'b0;
        nak({~TC, cs, 1'b0});
        nak({TC, ~cs, 1'b1});
        $display("test refuse done");
        i_sebw_master_model.soft_reset();
        rd2(a);
        $display("test recover done");
        end_sim();
    end
endmodule : sebw_eeprom_port_tb_top
